// File: dv/tso_rx.sv
// Model of the receiving transport processor on the stream side.
`timescale 1ns/10ps
module tso_rx (
   input wire logic ref_clk,
   input wire logic stream_output_clock,
   input wire logic [7:0] packet_byte_out,
   input wire logic packet_start_strobe,
   input wire logic packet_valid_strobe,
   input wire logic block_error_n
);
   logic [7:0] pkt[$];
   int n_pkts = 0, n_start = 0, n_err = 0, n_gap_bad = 0, n_skew = 0, n_clk = 0;
   logic in_pkt = 1'b0;
   logic [10:0] last = 11'h001;
   always @(posedge stream_output_clock) begin
      n_clk++;
      if (packet_valid_strobe === 1'b1) begin
         if (packet_start_strobe === 1'b1) begin
            pkt.delete();
            n_start = 0;
            n_err = 0;
         end
         pkt.push_back(packet_byte_out);
         n_start += int'(packet_start_strobe);
         n_err += int'(!block_error_n);
         in_pkt = 1'b1;
      end else begin
         n_pkts += int'(in_pkt);
         in_pkt = 1'b0;
         if ({packet_byte_out, packet_start_strobe, block_error_n} !== 10'h001) n_gap_bad++;
      end
   end
   // A change while the clock is high would eat into the hold after the rising edge.
   always @(posedge ref_clk) begin
      #1;
      if ({packet_byte_out, packet_start_strobe, packet_valid_strobe, block_error_n} !== last
          && stream_output_clock !== 1'b0) n_skew++;
      last = {packet_byte_out, packet_start_strobe, packet_valid_strobe, block_error_n};
   end
endmodule : tso_rx

// File: dv/tso_top_tb.sv
// Self-checking bench for the stream output stage.
`timescale 1ns/10ps
`define CHK(a, b) begin n_tests++; if ((a) !== (b)) begin fail_count++; \
   $display("BAD t=%0t got %h exp %h", $time, a, b); end end
module tso_top_tb;
   import tso_pkg::*;
   logic ref_clk = 1'b0, arst_n = 1'b0, up_valid = 1'b0, symbol_lock = 1'b0;
   logic reg_we = 1'b0, reg_re = 1'b0, up_ready, stream_output_clock, tei, unc;
   logic packet_start_strobe, packet_valid_strobe, block_error_n;
   logic [7:0] reg_addr = 8'h00, reg_wdata = 8'h00, reg_rdata, packet_byte_out, h;
   tso_word_t up_word = '0;
   tso_mode_t mode = '0;
   logic [31:0] seed = 32'd99241;
   logic [7:0] exp_q[$];
   int fail_count = 0, n_tests = 0, cyc = 0, d;
   tso_top tso_top_inst (.ref_clk, .arst_n, .up_word, .up_valid, .up_ready, .symbol_lock,
      .mode, .reg_addr, .reg_wdata, .reg_we, .reg_re, .reg_rdata, .stream_output_clock,
      .packet_byte_out, .packet_start_strobe, .packet_valid_strobe, .block_error_n);
   tso_rx tso_rx_inst (.ref_clk, .stream_output_clock, .packet_byte_out,
      .packet_start_strobe, .packet_valid_strobe, .block_error_n);
   function automatic logic [31:0] lfsr(input logic [31:0] s);
      return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
   endfunction : lfsr
   function automatic logic [7:0] half_exp(input tso_mode_t m);
      return 8'h08 + m.guard - m.constellation + m.hierarchy - m.code_rate;
   endfunction : half_exp
   task automatic stop_test;
      $display("compares %0d mismatches %0d", n_tests, fail_count);
      if (fail_count == 0 && n_tests > 0) begin
         $display("STATUS OK");
      end else begin
         $display("STATUS NOT OK");
      end
      $finish;
   endtask : stop_test
   task automatic reg_wr(input logic [7:0] a, input logic [7:0] v);
      @(posedge ref_clk);
      reg_addr <= a;
      reg_wdata <= v;
      reg_we <= 1'b1;
      @(posedge ref_clk);
      reg_we <= 1'b0;
   endtask : reg_wr
   task automatic reg_chk(input logic [7:0] a, input logic [7:0] v);
      @(posedge ref_clk);
      reg_addr <= a;
      reg_re <= 1'b1;
      @(posedge ref_clk);
      reg_re <= 1'b0;
      @(posedge ref_clk);
      #1;
      `CHK(reg_rdata, v)
   endtask : reg_chk
   task automatic send_pkt(input logic u, input logic [7:0] b1, input logic t);
      tso_word_t w;
      exp_q.delete();
      for (int i = 0; i < 188; i++) begin
         seed = lfsr(seed);
         w = {i == 0, u, (i == 0) ? 8'h47 : (i == 1) ? b1 : seed[7:0]};
         exp_q.push_back((i == 1 && u && t) ? (w.data | 8'h80) : w.data);
         up_word <= w;
         up_valid <= 1'b1;
         do @(negedge ref_clk); while (up_ready !== 1'b1);
         @(posedge ref_clk);
      end
      up_valid <= 1'b0;
   endtask : send_pkt
   initial begin
      forever #5 ref_clk = ~ref_clk;
   end
   // The ceiling leaves room for four fast-mode packets and the clock windows.
   always @(posedge ref_clk) begin
      cyc++;
      if (cyc == 20000) begin
         fail_count++;
         stop_test();
      end
   end
   initial begin
      repeat (20) @(posedge ref_clk);
      arst_n <= 1'b1;
      reg_chk(REG_CLK_CTRL, 8'h01);
      reg_chk(REG_OUT_CTRL, 8'h03);
      reg_wr(8'h7e, 8'h33);
      reg_chk(8'h7e, 8'h00);
      d = tso_rx_inst.n_clk;
      repeat (50) @(posedge ref_clk);
      `CHK(tso_rx_inst.n_clk - d, 0)
      $display("register test done");
      for (int j = 0; j < 3; j++) begin
         seed = lfsr(seed);
         @(posedge ref_clk);
         symbol_lock <= 1'b1;
         mode <= (j == 0) ? 9'h198 : (j == 2) ? 9'h044 :
            {seed[1:0], 2'(seed[3:2] % 3), seed[5:4], 3'(seed[8:6] % 5)};
         repeat (40) @(posedge ref_clk);
         h = half_exp(mode);
         d = tso_rx_inst.n_clk;
         repeat (64 * h) @(posedge ref_clk);
         `CHK((tso_rx_inst.n_clk - d) inside {[31:33]}, 1'b1)
         $display("clock test %0d done", j);
      end
      reg_wr(REG_CLK_CTRL, 8'h00);
      reg_chk(REG_CLK_CTRL, 8'h00);
      reg_wr(REG_CLK_CTRL, 8'h01);
      reg_chk(REG_CLK_CTRL, 8'h01);
      for (int p = 0; p < 4; p++) begin
         tei = (p < 2);
         unc = (p != 1);
         seed = lfsr(seed);
         reg_wr(REG_OUT_CTRL, (p == 0) ? 8'h03 : {7'h00, tei});
         fork
            send_pkt(unc, (p == 1) ? seed[7:0] : (p == 2) ? 8'h80 : 8'h00, tei);
            begin
               repeat (60) @(posedge ref_clk);
               #1;
               if (p == 0) `CHK({up_ready, packet_valid_strobe}, 2'b00)
               reg_wr(REG_OUT_CTRL, {7'h00, tei});
               if (p == 0) begin
                  // The busy bit must read back while the first packet is on the link.
                  repeat (10) @(posedge ref_clk);
                  reg_chk(REG_OUT_CTRL, 8'h81);
               end
            end
         join
         for (int k = 0; k < 3000 && tso_rx_inst.n_pkts == p; k++) @(posedge ref_clk);
         `CHK(tso_rx_inst.pkt.size(), 188)
         `CHK(tso_rx_inst.n_start, 1)
         `CHK(tso_rx_inst.n_err, unc ? 188 : 0)
         for (int i = 0; i < 188; i++) `CHK(tso_rx_inst.pkt[i], exp_q[i])
         $display("packet test %0d done", p);
      end
      `CHK(tso_rx_inst.n_gap_bad, 0)
      `CHK(tso_rx_inst.n_skew, 0)
      stop_test();
   end
endmodule : tso_top_tb

// File: rtl/tso_top.sv
// Transport stream output stage with its eight-entry byte FIFO.
`timescale 1ns/10ps
module tso_fifo #(
   parameter int WIDTH = 10,
   parameter int DEPTH = 8
) (
   input wire logic ref_clk,
   input wire logic arst_n,
   input wire logic [WIDTH-1:0] in_data,
   input wire logic in_valid,
   output logic in_ready,
   output logic [WIDTH-1:0] out_data,
   output logic out_valid,
   input wire logic out_ready
);
   localparam int AW = (DEPTH > 1) ? $clog2(DEPTH) : 1;
   typedef struct packed {
      logic [AW-1:0] wp;
      logic [AW-1:0] rp;
      logic [AW:0] cnt;
   } tso_fifo_st_t;
   tso_fifo_st_t st_reg;
   tso_fifo_st_t st_next;
   logic [WIDTH-1:0] mem [DEPTH];
   logic push;
   logic pop;

   initial begin
      if (DEPTH < 2 || (1 << AW) != DEPTH || WIDTH < 1) begin
         $error("tso_fifo: DEPTH must be a power of two of at least 2");
      end
   end

   assign in_ready = (st_reg.cnt != DEPTH[AW:0]);
   assign out_valid = (st_reg.cnt != '0);
   assign out_data = mem[st_reg.rp];
   assign push = in_valid && in_ready;
   assign pop = out_valid && out_ready;

   always_comb begin
      st_next = st_reg;
      if (push) begin
         st_next.wp = st_reg.wp + 1'b1;
      end
      if (pop) begin
         st_next.rp = st_reg.rp + 1'b1;
      end
      st_next.cnt = st_reg.cnt + {{AW{1'b0}}, push} - {{AW{1'b0}}, pop};
   end

   always_ff @(posedge ref_clk or negedge arst_n) begin
      if (!arst_n) begin
         st_reg <= '0;
      end else begin
         st_reg <= st_next;
      end
   end

   always_ff @(posedge ref_clk) begin
      if (push) begin
         mem[st_reg.wp] <= in_data;
      end
   end
endmodule : tso_fifo

//Contract
//RQ1: Error marking on sets header error bit.
//RQ2: Error marking off passes header bit unchanged.
//RQ3: Stream drives only while enable_n cleared.
//RQ4: Sync byte drifts at most one clock.
//RQ5: Output clock runs free after symbol lock.
//RQ6: Invert set: outputs change on falling edge.
//RQ7: 188 consecutive bytes; data low in gaps.
//RQ8: Start strobe only on first byte.
//RQ9: Valid high from first to last byte.
//RQ10: Error low whole packet when uncorrectable.
//RQ11: Clock rate follows transmission mode settings.
//RQ12: Gaps: strobes low, error output high.
//RQ13: Receiver samples rising edge while valid.
module tso_top (
   input wire logic ref_clk,
   input wire logic arst_n,
   input wire tso_pkg::tso_word_t up_word,
   input wire logic up_valid,
   output logic up_ready,
   input wire logic symbol_lock,
   input wire tso_pkg::tso_mode_t mode,
   input wire logic [7:0] reg_addr,
   input wire logic [7:0] reg_wdata,
   input wire logic reg_we,
   input wire logic reg_re,
   output logic [7:0] reg_rdata,
   output logic stream_output_clock,
   output logic [7:0] packet_byte_out,
   output logic packet_start_strobe,
   output logic packet_valid_strobe,
   output logic block_error_n
);
   import tso_pkg::*;

   tso_state_t s_reg;
   tso_state_t s_next;
   tso_word_t head;
   logic head_valid;
   logic pop;
   logic tick;
   logic upd;
   logic [FIFO_W-1:0] head_bits;

   tso_fifo #(.WIDTH(FIFO_W), .DEPTH(FIFO_D)) u_fifo (
      .ref_clk(ref_clk),
      .arst_n(arst_n),
      .in_data(up_word),
      .in_valid(up_valid),
      .in_ready(up_ready),
      .out_data(head_bits),
      .out_valid(head_valid),
      .out_ready(pop)
   );
   assign head = head_bits;

   // The clock toggles at the end of each half period while lock holds. [RQ5] [RQ11]
   assign tick = symbol_lock && (s_reg.div_cnt == 8'h00);
   // A toggle to low with invert set, or to high with invert clear, moves the outputs. [RQ6]
   assign upd = tick && (s_reg.clk_out == s_reg.clkinv);
   // The buffer stalls while the stream is disabled, so back-pressure reaches upstream. [RQ3]
   assign pop = upd && !s_reg.oe_n && head_valid && (s_reg.active || head.first);

   always_comb begin
      s_next = s_reg;
      if (!symbol_lock) begin
         s_next.div_cnt = 8'h00;
         s_next.clk_out = 1'b0;
      end else if (tick) begin
         s_next.div_cnt = tso_half_period(mode) - 8'h01; // [RQ11]
         s_next.clk_out = !s_reg.clk_out; // [RQ5]
      end else begin
         s_next.div_cnt = s_reg.div_cnt - 8'h01;
      end
      if (upd) begin
         s_next.byte_out = 8'h00; // [RQ7]
         s_next.start_out = 1'b0;
         s_next.valid_out = 1'b0;
         s_next.err_n_out = 1'b1; // [RQ12]
         if (s_reg.oe_n) begin
            s_next.active = 1'b0; // [RQ3]
         end else if (s_reg.active) begin
            // An underrun inside a packet still spends the clock and flags the packet bad.
            s_next.idx = s_reg.idx + 8'h01; // [RQ7]
            s_next.pkt_err = s_reg.pkt_err || !head_valid;
            s_next.byte_out = head_valid ? head.data : 8'h00;
            // The header error bit sits in the byte that this update sends as index one.
            if (s_next.idx == TEI_IDX && s_reg.error_mark_enable && s_reg.pkt_err) begin
               s_next.byte_out = s_next.byte_out | TEI_MASK; // [RQ1]
            end
            s_next.valid_out = 1'b1; // [RQ9]
            s_next.err_n_out = !s_next.pkt_err; // [RQ10]
            s_next.active = (s_reg.idx != PKT_LEN - 8'h02);
         end else if (head_valid && head.first) begin
            // A packet starts on the first output clock after its first byte arrives. [RQ4]
            s_next.active = 1'b1;
            s_next.idx = 8'h00;
            s_next.pkt_err = head.uncorr;
            s_next.byte_out = head.data;
            s_next.start_out = 1'b1; // [RQ8]
            s_next.valid_out = 1'b1; // [RQ9]
            s_next.err_n_out = !head.uncorr; // [RQ10]
         end
      end
      if (reg_we && reg_addr == REG_CLK_CTRL) begin
         s_next.clkinv = reg_wdata[CLKINV_BIT];
      end
      if (reg_we && reg_addr == REG_OUT_CTRL) begin
         s_next.error_mark_enable = reg_wdata[ERROR_MARK_ENABLE_BIT];
         s_next.oe_n = reg_wdata[OE_N_BIT];
      end
      if (reg_re) begin
         s_next.rdata = 8'h00;
         if (reg_addr == REG_CLK_CTRL) begin
            s_next.rdata[CLKINV_BIT] = s_reg.clkinv;
         end else if (reg_addr == REG_OUT_CTRL) begin
            s_next.rdata[ERROR_MARK_ENABLE_BIT] = s_reg.error_mark_enable;
            s_next.rdata[OE_N_BIT] = s_reg.oe_n;
            s_next.rdata[BUSY_BIT] = s_reg.active;
         end
      end
   end

   always_ff @(posedge ref_clk or negedge arst_n) begin
      if (!arst_n) begin
         s_reg <= '0;
         s_reg.err_n_out <= 1'b1;
         s_reg.clkinv <= CLKINV_RST;
         s_reg.error_mark_enable <= ERROR_MARK_ENABLE_RST;
         s_reg.oe_n <= OE_N_RST;
      end else begin
         s_reg <= s_next;
      end
   end

   assign stream_output_clock = s_reg.clk_out;
   assign packet_byte_out = s_reg.byte_out;
   assign packet_start_strobe = s_reg.start_out;
   assign packet_valid_strobe = s_reg.valid_out;
   assign block_error_n = s_reg.err_n_out;
   assign reg_rdata = s_reg.rdata;

   AST_TEI_SET: assert property (@(posedge ref_clk) disable iff (!arst_n) // [RQ1]
      upd && s_reg.active && !s_reg.oe_n && s_reg.idx == TEI_IDX - 8'h01 && s_reg.error_mark_enable
      && s_reg.pkt_err |=> packet_byte_out[7])
      else $error("error bit not forced in marked packet");
   AST_TEI_PASS: assert property (@(posedge ref_clk) disable iff (!arst_n) // [RQ2]
      upd && s_reg.active && !s_reg.oe_n && head_valid && !s_reg.error_mark_enable
      |=> packet_byte_out == $past(head.data))
      else $error("byte altered while marking is off");
   AST_OE_OFF: assert property (@(posedge ref_clk) disable iff (!arst_n) // [RQ3]
      upd && s_reg.oe_n |=> !packet_valid_strobe && packet_byte_out == 8'h00)
      else $error("stream driven while disabled");
   AST_CLK_RUN: assert property (@(posedge ref_clk) disable iff (!arst_n) // [RQ5]
      symbol_lock && s_reg.div_cnt == 8'h00 |=> stream_output_clock != $past(stream_output_clock))
      else $error("output clock missed a toggle under lock");
   AST_EDGE: assert property (@(posedge ref_clk) disable iff (!arst_n) // [RQ6]
      $changed(packet_valid_strobe) |-> stream_output_clock == !$past(s_reg.clkinv))
      else $error("outputs changed on the wrong clock edge");
   AST_GAP_DATA: assert property (@(posedge ref_clk) disable iff (!arst_n) // [RQ7]
      !packet_valid_strobe |-> packet_byte_out == 8'h00)
      else $error("data not low in gap");
   AST_START_FIRST: assert property (@(posedge ref_clk) disable iff (!arst_n) // [RQ8]
      packet_start_strobe |-> packet_valid_strobe && s_reg.idx == 8'h00)
      else $error("start strobe not on first byte");
   AST_VALID_LEN: assert property (@(posedge ref_clk) disable iff (!arst_n) // [RQ9]
      $fell(packet_valid_strobe) && !$past(s_reg.oe_n) |-> $past(s_reg.idx) == PKT_LEN - 8'h01)
      else $error("packet length not 188 bytes");
   AST_ERR_HOLD: assert property (@(posedge ref_clk) disable iff (!arst_n) // [RQ10]
      packet_valid_strobe && !block_error_n |=> !packet_valid_strobe || packet_start_strobe
      || !block_error_n)
      else $error("block error released inside packet");
   AST_GAP_STROBES: assert property (@(posedge ref_clk) disable iff (!arst_n) // [RQ12]
      !packet_valid_strobe |-> !packet_start_strobe && block_error_n)
      else $error("strobes active in gap");
endmodule : tso_top

// File: shared/tso_pkg.sv
// Shared constants, register map and state types of the stream output stage.
package tso_pkg;
   localparam logic [7:0] REG_CLK_CTRL = 8'h50;
   localparam logic [7:0] REG_OUT_CTRL = 8'h5a;
   localparam int CLKINV_BIT = 0;
   localparam int ERROR_MARK_ENABLE_BIT = 0;
   localparam int OE_N_BIT = 1;
   localparam int BUSY_BIT = 7;
   localparam logic CLKINV_RST = 1'b1;
   localparam logic ERROR_MARK_ENABLE_RST = 1'b1;
   localparam logic OE_N_RST = 1'b1;
   localparam logic [7:0] PKT_LEN = 8'hbc;
   localparam logic [7:0] TEI_IDX = 8'h01;
   localparam logic [7:0] TEI_MASK = 8'h80;
   localparam logic [7:0] HALF_BASE = 8'h02;
   localparam int FIFO_W = 10;
   localparam int FIFO_D = 8;

   // One upstream byte: first-byte mark, packet uncorrectable mark, data.
   typedef struct packed {
      logic first;
      logic uncorr;
      logic [7:0] data;
   } tso_word_t;

   // Transmission settings that set the output clock rate.
   typedef struct packed {
      logic [1:0] guard;
      logic [1:0] constellation;
      logic [1:0] hierarchy;
      logic [2:0] code_rate;
   } tso_mode_t;

   typedef struct packed {
      logic [7:0] div_cnt;
      logic clk_out;
      logic active;
      logic [7:0] idx;
      logic pkt_err;
      logic [7:0] byte_out;
      logic start_out;
      logic valid_out;
      logic err_n_out;
      logic clkinv;
      logic error_mark_enable;
      logic oe_n;
      logic [7:0] rdata;
   } tso_state_t;

   // Denser modes carry more bits per symbol, so the clock half period shrinks.
   function automatic logic [7:0] tso_half_period(input tso_mode_t m);
      logic [7:0] h;
      h = HALF_BASE + {6'h00, m.guard} + {6'h00, 2'h2 - m.constellation}
          + {6'h00, m.hierarchy} + {5'h00, 3'h4 - m.code_rate};
      return h;
   endfunction : tso_half_period
endpackage : tso_pkg
